//--- design/sdja_pkg.sv
// package: register map, field positions, reset values and loop constants of the smoother
package sdja_pkg;
  // printed register offsets are indexes; byte address is four times the index
  localparam logic [7:0] SDJA_IDX_CTRL_CH0 = 8'h07;
  localparam logic [7:0] SDJA_IDX_CTRL_CH1 = 8'h0F;
  localparam logic [7:0] SDJA_IDX_CTRL_CH2 = 8'h17;
  localparam logic [7:0] SDJA_IDX_STATUS = 8'h1F;
  localparam logic [7:0] SDJA_ADDR_CTRL_CH0 = {SDJA_IDX_CTRL_CH0[5:0], 2'h0};
  localparam logic [7:0] SDJA_ADDR_CTRL_CH1 = {SDJA_IDX_CTRL_CH1[5:0], 2'h0};
  localparam logic [7:0] SDJA_ADDR_CTRL_CH2 = {SDJA_IDX_CTRL_CH2[5:0], 2'h0};
  localparam logic [7:0] SDJA_ADDR_STATUS = {SDJA_IDX_STATUS[5:0], 2'h0};
  localparam int SDJA_NUM_CH = 3;
  // control field positions
  localparam int SDJA_BIT_DEPTH_LOW = 0;
  localparam int SDJA_BIT_PATH_SEL = 1;
  localparam int SDJA_BIT_DEPTH_HIGH = 2;
  localparam int SDJA_BIT_FIFO_RESET = 3;
  localparam int SDJA_BIT_FAST_OFF = 4;
  localparam int SDJA_CTRL_W = 5;
  localparam logic [4:0] SDJA_CTRL_RESET = 5'h03;
  // status field positions
  localparam int SDJA_ST_FILL_LSB = 0;
  localparam int SDJA_ST_OVERRUN = 8;
  localparam int SDJA_ST_UNDERRUN = 9;
  localparam int SDJA_ST_FAST_ACTIVE = 10;
  // buffer shape
  localparam int SDJA_FIFO_DEPTH = 16;
  localparam int SDJA_FIFO_AW = 4;
  // fill targets for the three depth modes
  localparam logic [4:0] SDJA_TARGET_16 = 5'h04;
  localparam logic [4:0] SDJA_TARGET_32 = 5'h08;
  localparam logic [4:0] SDJA_TARGET_128 = 5'h0C;
  // super pattern figures: pulses per pattern over sts-1 periods
  localparam int SDJA_SUPER_PULSES = 1864;
  localparam int SDJA_SUPER_PERIODS = 2160;
  // nco: 16 bit phase, base step is the mean super pattern rate of a 200 ns link clock at 40 MHz
  // a step of one link clock per 8 cycles would outrun the gapped input and underrun the buffer
  localparam int SDJA_PHASE_W = 16;
  localparam logic [15:0] SDJA_STEP_BASE = 16'(32'h0000_2000 * SDJA_SUPER_PULSES / SDJA_SUPER_PERIODS);
  localparam int SDJA_GAIN_FAST = 7;
  localparam int SDJA_GAIN_SLOW = 3;
  // fast recovery lock window, 50 ms at 40 MHz
  localparam int SDJA_RECOVER_MS = 50;
  localparam int SDJA_CLK_KHZ = 40000;
  localparam int SDJA_RECOVER_CYC = SDJA_RECOVER_MS * SDJA_CLK_KHZ;
  typedef enum logic [1:0] {
    SDJA_ST_IDLE = 2'b00,
    SDJA_ST_FILL = 2'b01,
    SDJA_ST_RUN = 2'b10
  } sdja_state_t;
endpackage

//--- design/sdja_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sdja_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

//--- design/sdja_fifo.sv
// bit buffer between the gapped input clock and the smoothed line clock
`timescale 1ns/10ps
`default_nettype none
module sdja_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] fill
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];
  assign fill = count_ff;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/sdja_top.sv
// jitter smoother channel for de-synchroniser use, with apb control registers
// Functional notes
// - each super sequence holds 1864 pulses in 2160 periods and the line gives 1864 even pulses.
// - in ds3 mode the channel takes a stream of super sequences with data and drives a smooth line.
// - with the recovery-off bit at zero the smoother uses fast tracking to relock within 50 ms.
// - fast recovery can be turned off only under host control; in hardware mode it stays on.
// - the control registers of channels 0, 1 and 2 sit at indexes 0x07, 0x0F and 0x17.
// - bits 7 to 5 read zero; bits 4 to 0 are off, reset, depth high, path select, depth low.
`timescale 1ns/10ps
`default_nettype none
module sdja_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_clock_input,
  input wire logic tx_data_input,
  input wire logic hw_mode_strap,
  output logic line_clk_out,
  output logic line_data_out,
  output logic line_bit_strobe
);
  import sdja_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge finding

  logic [2:0] pins_sync;
  logic link_clk_s;
  logic link_data_s;
  logic hw_mode_s;
  logic link_clk_prev_ff;
  logic link_data_prev_ff;
  logic link_rise;

  sdja_sync #(
    .WIDTH(3)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({hw_mode_strap, tx_data_input, tx_clock_input}),
    .sync_out(pins_sync)
  );

  assign link_clk_s = pins_sync[0];
  assign link_data_s = pins_sync[1];
  assign hw_mode_s = pins_sync[2];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link_clk_prev_ff <= 1'b0;
      link_data_prev_ff <= 1'b0;
    end else begin
      link_clk_prev_ff <= link_clk_s;
      link_data_prev_ff <= link_data_s;
    end
  end

  // a gap in the incoming clock simply yields no rising edge, so no bit is stored
  assign link_rise = link_clk_s && !link_clk_prev_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // apb register file

  logic [SDJA_CTRL_W-1:0] ctrl_ff [SDJA_NUM_CH];
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic setup;
  logic access;
  logic hit_status;
  logic [1:0] hit_ch;
  logic hit_any;
  logic overrun_ff;
  logic underrun_ff;
  logic set_overrun;
  logic set_underrun;
  logic clr_overrun;
  logic clr_underrun;
  logic [4:0] fifo_fill;
  logic fast_active;

  assign setup = psel && !penable;
  assign access = psel && penable;

  always_comb begin
    hit_ch = 2'h3;
    hit_status = (paddr == SDJA_ADDR_STATUS);
    case (paddr)
      SDJA_ADDR_CTRL_CH0: hit_ch = 2'h0;
      SDJA_ADDR_CTRL_CH1: hit_ch = 2'h1;
      SDJA_ADDR_CTRL_CH2: hit_ch = 2'h2;
      default: hit_ch = 2'h3;
    endcase
  end

  assign hit_any = (hit_ch != 2'h3) || hit_status;

  // zero wait states: the answer is prepared in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !hit_any;
      if (hit_ch != 2'h3) begin
        prdata_ff <= {27'h000_0000, ctrl_ff[hit_ch]};
      end else if (hit_status) begin
        prdata_ff <= {21'h00_0000, fast_active, underrun_ff, overrun_ff, 3'h0, fifo_fill};
      end else begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // only the low five bits are stored, so the upper three can never read back
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < SDJA_NUM_CH; i++) begin
        ctrl_ff[i] <= SDJA_CTRL_RESET;
      end
    end else if (access && pwrite && hit_ch != 2'h3) begin
      ctrl_ff[hit_ch] <= pwdata[SDJA_CTRL_W-1:0];
    end
  end

  assign clr_overrun = access && pwrite && hit_status && pwdata[SDJA_ST_OVERRUN];
  assign clr_underrun = access && pwrite && hit_status && pwdata[SDJA_ST_UNDERRUN];

  // sticky error flags, write one to clear; a new event in the clear cycle wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
      underrun_ff <= 1'b0;
    end else begin
      overrun_ff <= set_overrun || (overrun_ff && !clr_overrun);
      underrun_ff <= set_underrun || (underrun_ff && !clr_underrun);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel 0 controls; channels 1 and 2 only hold configuration here

  logic path_on;
  logic fifo_clear;
  logic [4:0] fill_target;
  logic fast_off_req;

  assign path_on = ctrl_ff[0][SDJA_BIT_PATH_SEL];
  assign fifo_clear = ctrl_ff[0][SDJA_BIT_FIFO_RESET] || !path_on;
  assign fast_off_req = ctrl_ff[0][SDJA_BIT_FAST_OFF];
  // the strap forces fast recovery whatever software wrote
  assign fast_active = !fast_off_req || hw_mode_s;

  always_comb begin
    case ({ctrl_ff[0][SDJA_BIT_DEPTH_HIGH], ctrl_ff[0][SDJA_BIT_DEPTH_LOW]})
      2'b10: fill_target = SDJA_TARGET_32;
      2'b01: fill_target = SDJA_TARGET_16;
      2'b11: fill_target = SDJA_TARGET_128;
      default: fill_target = SDJA_TARGET_16;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // elastic buffer

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_bit;
  logic push_req;

  assign push_req = link_rise && path_on;
  assign set_overrun = push_req && !fifo_in_ready;

  sdja_fifo #(
    .WIDTH(1),
    .DEPTH(SDJA_FIFO_DEPTH),
    .AW(SDJA_FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(fifo_clear),
    .in_valid(push_req),
    .in_ready(fifo_in_ready),
    .in_data(link_data_prev_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_bit),
    .fill(fifo_fill)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // smoothing nco: step follows the buffer fill so the average rate matches the input

  sdja_state_t state_ff;
  logic [15:0] phase_ff;
  logic [15:0] step;
  logic signed [6:0] fill_err;
  logic signed [17:0] step_wide;
  logic [16:0] phase_sum;
  logic tick;

  assign fill_err = $signed({2'b00, fifo_fill}) - $signed({2'b00, fill_target});

  // fast tracking trades some residual jitter for a short relock after a switch
  always_comb begin
    if (fast_active) begin
      // widen before shifting so the gain is not lost in the 7 bit error
      step_wide = $signed({2'b00, SDJA_STEP_BASE}) + (18'(fill_err) <<< SDJA_GAIN_FAST);
    end else begin
      step_wide = $signed({2'b00, SDJA_STEP_BASE}) + (18'(fill_err) <<< SDJA_GAIN_SLOW);
    end
    if (step_wide < 18'sd1) begin
      step = 16'h0001;
    end else if (step_wide > 18'sh0FFFF) begin
      step = 16'hFFFF;
    end else begin
      step = step_wide[15:0];
    end
  end

  assign phase_sum = {1'b0, phase_ff} + {1'b0, step};
  // even spacing: one line bit per nco overflow, gaps are spread over the pattern
  assign tick = (state_ff == SDJA_ST_RUN) && phase_sum[16];
  assign fifo_pop = tick && fifo_out_valid;
  assign set_underrun = tick && !fifo_out_valid;

  always_ff @(posedge core_clk) begin
    if (!rst_n || fifo_clear) begin
      state_ff <= SDJA_ST_IDLE;
    end else begin
      case (state_ff)
        SDJA_ST_IDLE: begin
          if (fifo_fill != 5'h00) begin
            state_ff <= SDJA_ST_FILL;
          end
        end
        SDJA_ST_FILL: begin
          if (fifo_fill >= fill_target) begin
            state_ff <= SDJA_ST_RUN;
          end
        end
        SDJA_ST_RUN: begin
          if (set_underrun) begin
            state_ff <= SDJA_ST_IDLE;
          end
        end
        default: state_ff <= SDJA_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || fifo_clear) begin
      phase_ff <= 16'h0000;
    end else if (state_ff == SDJA_ST_RUN) begin
      phase_ff <= phase_sum[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line outputs: smoothed when the path is selected, else a straight copy

  logic line_clk_ff;
  logic line_data_ff;
  logic line_strobe_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      line_clk_ff <= 1'b0;
      line_data_ff <= 1'b0;
      line_strobe_ff <= 1'b0;
    end else if (!path_on) begin
      line_clk_ff <= link_clk_prev_ff;
      line_data_ff <= link_data_prev_ff;
      line_strobe_ff <= link_rise;
    end else begin
      line_strobe_ff <= fifo_pop;
      if (fifo_pop) begin
        line_data_ff <= fifo_bit;
        line_clk_ff <= 1'b1;
      end else if (phase_ff[15]) begin
        line_clk_ff <= 1'b0;
      end
    end
  end

  assign line_clk_out = line_clk_ff;
  assign line_data_out = line_data_ff;
  assign line_bit_strobe = line_strobe_ff;
endmodule
`default_nettype wire

//--- verification/sdja_top_properties.sv
// checker: register and line output properties of the smoother channel
`timescale 1ns/10ps
`default_nettype none
module sdja_top_checker
  import sdja_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_clock_input,
  input wire logic tx_data_input,
  input wire logic hw_mode_strap,
  input wire logic line_clk_out,
  input wire logic line_data_out,
  input wire logic line_bit_strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] sh_ff [3];
  logic acc;
  logic hit;
  logic fast;
  logic [1:0] ch;
  assign acc = psel & penable;
  assign hit = paddr inside {SDJA_ADDR_CTRL_CH0, SDJA_ADDR_CTRL_CH1, SDJA_ADDR_CTRL_CH2};
  assign ch = (paddr == SDJA_ADDR_CTRL_CH0) ? 2'h0 : (paddr == SDJA_ADDR_CTRL_CH1) ? 2'h1 : 2'h2;
  // strap is raw here, so the flag is only judged once it has been quiet a while
  assign fast = !sh_ff[0][SDJA_BIT_FAST_OFF] | hw_mode_strap;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) sh_ff[i] <= 5'h03;
    end else if (acc && pwrite && hit) begin
      sh_ff[ch] <= pwdata[4:0];
    end
  end
  ////////////////////////////////////////
  sequence rd_acc;
    psel && penable && !pwrite;
  endsequence
  unmapped_zero_a: assert property (rd_acc ##0 !hit && paddr != SDJA_ADDR_STATUS |-> pready && prdata == 32'h0)
    else $error("unmapped read not zero");
  unmapped_err_a: assert property (acc && !hit && paddr != SDJA_ADDR_STATUS |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (acc && (hit || paddr == SDJA_ADDR_STATUS) |-> !pslverr)
    else $error("error on mapped address");
  upper_zero_a: assert property (rd_acc ##0 hit |-> prdata[31:5] == 27'h0)
    else $error("upper control bits not zero");
  ctrl_readback_a: assert property (rd_acc ##0 hit |-> prdata[4:0] == sh_ff[ch])
    else $error("control readback differs");
  status_shape_a: assert property (rd_acc ##0 paddr == SDJA_ADDR_STATUS
    |-> prdata[4:0] <= 5'h10 && prdata[31:11] == 21'h0)
    else $error("status fill out of range");
  fast_flag_a: assert property ($stable(fast) [*8] ##0 rd_acc ##0 paddr == SDJA_ADDR_STATUS
    |-> prdata[SDJA_ST_FAST_ACTIVE] == fast)
    else $error("fast recovery flag wrong");
  strobe_pulse_a: assert property (line_bit_strobe |=> !line_bit_strobe)
    else $error("line strobe longer than one cycle");
endmodule
bind sdja_top sdja_top_checker sdja_top_checker_inst (.core_clk(core_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_clock_input(tx_clock_input),
  .tx_data_input(tx_data_input), .hw_mode_strap(hw_mode_strap), .line_clk_out(line_clk_out),
  .line_data_out(line_data_out), .line_bit_strobe(line_bit_strobe));
`default_nettype wire

//--- verification/sdja_mapper.sv
// partner model: mapper sending the gapped super pattern with data
`timescale 1ns/10ps
`default_nettype none
module sdja_mapper (
  input wire logic run,
  output var logic tx_clk,
  output var logic tx_data,
  output var int pulses
);
  initial begin
    tx_clk = 1'b0;
    tx_data = 1'b0;
    pulses = 0;
  end
  // a gap slot toggles data so a stale bit is never mistaken for a good one
  task automatic slot(input logic pulse);
    if (pulse) begin
      tx_data = pulses[0] ^ pulses[2] ^ pulses[5];
      #100 tx_clk = 1'b1;
      #100 tx_clk = 1'b0;
      pulses++;
    end else begin
      tx_data = ~tx_data;
      #200;
    end
  endtask
  task automatic minor(input int n, input logic gap);
    repeat (n) slot(1'b1);
    if (gap) slot(1'b0);
  endtask
  task automatic major(input logic b);
    repeat (63) minor(7, 1'b1);
    repeat (b ? 35 : 36) minor(5, 1'b1);
    if (b) minor(6, 1'b0);
  endtask
  // clock stands still between super sequences
  always begin
    wait (run === 1'b1);
    #13;
    major(1'b0);
    major(1'b0);
    major(1'b1);
  end
endmodule
`default_nettype wire

//--- verification/tb_sdja_top.sv
// testbench: register tests and one super pattern through channel 0
`timescale 1ns/10ps
`default_nettype none
module tb_sdja_top;
  import sdja_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hw_mode_strap = 1'b0;
  logic run = 1'b0;
  logic cap = 1'b0;
  logic took = 1'b0;
  logic clk_lo = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_clock_input, tx_data_input;
  logic line_clk_out, line_data_out, line_bit_strobe;
  logic [31:0] rd;
  logic err;
  logic [7:0] ca [3] = '{SDJA_ADDR_CTRL_CH0, SDJA_ADDR_CTRL_CH1, SDJA_ADDR_CTRL_CH2};
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int nlin = 0;
  int bad = 0;
  int pulses;
  always #12.5 core_clk = ~core_clk;
  sdja_top sdja_top_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clock_input(tx_clock_input), .tx_data_input(tx_data_input),
    .hw_mode_strap(hw_mode_strap), .line_clk_out(line_clk_out),
    .line_data_out(line_data_out), .line_bit_strobe(line_bit_strobe));
  sdja_mapper sdja_mapper_inst (.run(run), .tx_clk(tx_clock_input), .tx_data(tx_data_input),
    .pulses(pulses));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  // line data is registered with its strobe and holds until the next pop, so judging it one cycle later is safe
  // each line bit needs the line clock high with its strobe and a low phase before it
  always @(posedge core_clk) begin
    took <= cap && line_bit_strobe === 1'b1;
    clk_lo <= (line_clk_out === 1'b0) || (clk_lo && !(cap && line_bit_strobe === 1'b1));
    if (cap && line_bit_strobe === 1'b1 && (line_clk_out !== 1'b1 || !clk_lo)) bad++;
    if (took) begin
      if (line_data_out !== (nlin[0] ^ nlin[2] ^ nlin[5])) bad++;
      nlin++;
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, SDJA_ADDR_STATUS, 32'h0);
    check(rd, 32'h400);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, ca[i], 32'h0);
      check(rd, 32'h03);
      check(32'(err), 32'h0);
      apb(1'b1, ca[i], 32'hFFFFFFFF);
      apb(1'b0, ca[i], 32'h0);
      check(rd, 32'h1F);
      apb(1'b1, ca[i], 32'hE0 | 32'(i));
      apb(1'b0, ca[i], 32'h0);
      check(rd, 32'(i));
    end
    $display("test control registers done");
    apb(1'b1, 8'h07, 32'h1F);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h07, 32'h0);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b0, ca[0], 32'h0);
    check(rd, 32'h0);
    $display("test unmapped access done");
    apb(1'b1, ca[0], 32'h06);
    repeat (8) @(posedge core_clk);
    apb(1'b0, SDJA_ADDR_STATUS, 32'h0);
    check(32'(rd[SDJA_ST_FAST_ACTIVE]), 32'h1);
    apb(1'b1, ca[0], 32'h16);
    repeat (8) @(posedge core_clk);
    apb(1'b0, SDJA_ADDR_STATUS, 32'h0);
    check(32'(rd[SDJA_ST_FAST_ACTIVE]), 32'h0);
    hw_mode_strap <= 1'b1;
    repeat (8) @(posedge core_clk);
    apb(1'b0, SDJA_ADDR_STATUS, 32'h0);
    check(32'(rd[SDJA_ST_FAST_ACTIVE]), 32'h1);
    hw_mode_strap <= 1'b0;
    $display("test fast recovery done");
    apb(1'b1, ca[0], 32'h06);
    apb(1'b1, SDJA_ADDR_STATUS, 32'h300);
    cap <= 1'b1;
    run <= 1'b1;
    repeat (50) @(posedge core_clk);
    run <= 1'b0;
    while (pulses < 1864) @(posedge core_clk);
    repeat (400) @(posedge core_clk);
    cap <= 1'b0;
    check(32'(pulses), 32'd1864);
    check(32'(nlin >= 1848 && nlin <= 1864), 32'h1);
    check(32'(bad), 32'h0);
    apb(1'b0, SDJA_ADDR_STATUS, 32'h0);
    check(32'(rd[SDJA_ST_OVERRUN]), 32'h0);
    $display("test super pattern stream done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
